// ==== common/cmtc_pkg.sv ====
package cmtc_pkg;
   // ==========================================================
   // control word fields (bit 0 is the msb of the 16-bit word)
   // ==========================================================
   localparam int CW_MRST  = 15;              // master reset
   localparam int CW_RINT  = 14;              // reset interrupt request
   localparam int CW_JUMP  = 13;              // set jump met
   localparam int CW_DEND  = 12;              // device end at transfer start
   localparam int CW_CC_HI = 9;               // control code, bits 6..7
   localparam int CW_CC_LO = 8;
   localparam int CW_HSPD  = 7;               // high speed service request
   localparam int CW_DNUM  = 6;               // device number from counter/buffer
   localparam int CW_TTC   = 5;               // terminate on terminal count
   localparam int CW_CMP   = 4;               // compare mode
   localparam int CW_CLRI  = 3;               // clear interface select
   localparam int CW_CB_HI = 2;               // counter/buffer mode, bits 13..15
   localparam int CW_CB_LO = 0;
   // ==========================================================
   // status word fields
   // ==========================================================
   localparam int SW_SIOK  = 15;
   localparam int SW_RWOK  = 14;
   localparam int SW_IPND  = 13;
   localparam int SW_IACT  = 12;
   localparam int SW_XERR  = 11;
   localparam int SW_IDLE  = 10;
   localparam int SW_DEND  = 9;
   localparam int SW_EOT   = 8;
   localparam int SW_IN    = 7;
   localparam int SW_OUT   = 6;
   localparam int SW_TCNT  = 5;
   localparam int SW_NCMP  = 4;
   localparam int SW_CLRI  = 3;
   // ==========================================================
   // codes, reset values, timing
   // ==========================================================
   localparam logic [1:0] CC_NORMAL = 2'h0;   // order address word -> control
   localparam logic [1:0] CC_ADDR   = 2'h1;   // order address word -> cb
   localparam logic [1:0] CC_CTRL   = 2'h2;   // order control word -> cb
   localparam logic [1:0] CC_BOTH   = 2'h3;   // both, control word last
   localparam logic [2:0] CB_BUFFER = 3'h0;   // buffer mode
   localparam logic [2:0] CB_CNT_WR = 3'h1;   // count write words
   localparam logic [2:0] CB_CNT_RD = 3'h2;   // count read words
   localparam logic [2:0] CB_CNT_SR = 3'h3;   // count service requests
   localparam logic [2:0] CB_CNT_OR = 3'h4;   // count orders
   localparam logic [15:0] WORD_ZERO = 16'h0000;
   localparam int CLK_MHZ      = 250;
   localparam int SR_RATE_KHZ  = 200;
   localparam int SR_DELAY_CYC = (CLK_MHZ * 1000) / SR_RATE_KHZ;
   localparam int FIFO_DEPTH   = 32;
   localparam int WORD_W       = 16;
endpackage

// ==== common/cmtc_fifo_if.sv ====
`timescale 1ns/1ps
// word path between the channel side and the fifo
interface cmtc_fifo_if;
   logic [15:0] wrData;
   logic        wrValid;
   logic        wrReady;
   logic [15:0] rdData;
   logic        rdValid;
   logic        rdReady;
   modport fifo (input wrData, input wrValid, output wrReady,
                 output rdData, output rdValid, input rdReady);
   modport user (output wrData, output wrValid, input wrReady,
                 input rdData, input rdValid, output rdReady);
endinterface

// ==== rtl/cmtc_fifo.sv ====
`timescale 1ns/1ps
module cmtc_fifo
#(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32
)
(
   // clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // both sides
   cmtc_fifo_if.fifo f
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];            // word storage
   logic [AW-1:0]    wrPtr_r;                // next write slot
   logic [AW-1:0]    rdPtr_r;                // next read slot
   logic [AW:0]      count_r;                // words held
   logic             push;
   logic             pop;

   assign f.wrReady = (count_r != (AW+1)'(DEPTH));
   assign f.rdValid = (count_r != '0);
   assign f.rdData  = mem[rdPtr_r];
   assign push      = f.wrValid && f.wrReady;
   assign pop       = f.rdValid && f.rdReady;

   // ==========================================================
   // storage write, no reset needed on data
   // ==========================================================
   always_ff @(posedge clock)
   begin
      if (push)
      begin
         mem[wrPtr_r] <= f.wrData;
      end
   end

   // ==========================================================
   // pointers and fill level
   // ==========================================================
   always_ff @(posedge clock)
   begin
      if (!rst_b)
      begin
         wrPtr_r <= '0;
         rdPtr_r <= '0;
         count_r <= '0;
      end
      else
      begin
         if (push)
         begin
            wrPtr_r <= wrPtr_r + AW'(1);
         end
         if (pop)
         begin
            rdPtr_r <= rdPtr_r + AW'(1);
         end
         count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// ==== rtl/cmtc_channel_maint.sv ====
`timescale 1ns/1ps
// Behaviour
// - control order code steers word destination
// - high speed bypasses service request pacing
// - device number bit selects counter/buffer
// - rollover terminates when enabled
// - compare mode checks write words
// - select bit picks clear interface or end
// - counter/buffer mode field; buffer mode
// - io reset clears control and buffer
// - start io clears status; transfer clears some
// - idle ok bit; bit 1 always one
// - interrupt pending and active bits
// - transfer error sticky until start io
// - idle enable reflected directly
// - device end status flag
// - end of transfer status flag
// - read and write direction flags
// - terminal count status flag
// - no compare status flag
// - clear interface flag, start io clears
// - zero buffer gives jump to zero
// - master reset bit, clear if active
// - jump bit returns jump met
// - device end bit ends transfers immediately
// - reject start io while channel active
module cmtc_channel_maint
(
   // clock and reset
   input  wire logic        clock,
   input  wire logic        rst_b,
   // direct instructions from the processor side
   input  wire logic        directControl,
   input  wire logic        directWrite,
   input  wire logic        directRead,
   input  wire logic        directStatus,
   input  wire logic        startIo,
   input  wire logic        setIntReq,
   input  wire logic        intActive,
   input  wire logic [15:0] directData,
   output      logic [15:0] directResult,
   output      logic        startIoRejected,
   // wired device number
   input  wire logic [7:0]  wiredDevNum,
   // channel orders
   input  wire logic        channelIdleEnable,
   input  wire logic        orderControl,
   input  wire logic        orderWrite,
   input  wire logic        orderRead,
   input  wire logic        orderJump,
   input  wire logic        transferStart,
   input  wire logic [15:0] orderAddressWord,
   input  wire logic [15:0] orderControlWord,
   input  wire logic        writeValid,
   input  wire logic [15:0] writeData,
   output      logic        writeReady,
   output      logic        readValid,
   output      logic [15:0] readData,
   input  wire logic        readReady,
   input  wire logic        endOfTransfer,
   input  wire logic        transferErrorSignal,
   // answers to the channel
   output      logic        channelServiceRequest,
   output      logic        deviceEnd,
   output      logic        clearInterface,
   output      logic        jumpMet,
   output      logic [15:0] programDevNum,
   output      logic        intRequest
);
   import cmtc_pkg::*;

   // ==========================================================
   // state
   // ==========================================================
   typedef enum logic [2:0]
   {
      CMTC_IDLE = 3'b001,                     // no program running
      CMTC_RUN  = 3'b010,                     // program executing
      CMTC_DONE = 3'b100                      // terminated, wait for idle
   } cmtc_state_t;

   cmtc_state_t state_r;                      // program sequencer
   logic [15:0] ctrl_r;                       // control register
   logic [15:0] cb_r;                         // counter/buffer
   logic [15:0] cbNxt;
   logic        jump_r;                       // jump flag
   logic        intReq_r;                     // interrupt request
   logic        xerr_r, dend_r, eot_r, in_r, out_r, tcnt_r, ncmp_r, clri_r;
   logic [$clog2(SR_DELAY_CYC+1)-1:0] srCnt_r; // request pacing
   logic        masterReset;                  // control word bit 0
   logic        cwLoad;                       // a new control word arrives
   logic [15:0] cwNew;
   logic        rollover;
   logic        countEvt;
   logic        cmpFail;
   logic        terminate;
   logic        srTick;
   logic        sioAccept;
   logic        wrTake;
   logic [15:0] statusWord;                   // assembled status word
   cmtc_fifo_if fp ();

   // fifo holds write-order words until the counter/buffer takes them
   cmtc_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) uFifo
   (
      .clock (clock),
      .rst_b (rst_b),
      .f     (fp.fifo)
   );
   assign fp.wrData  = writeData;
   assign fp.wrValid = writeValid && (state_r == CMTC_RUN);
   assign writeReady = fp.wrReady && (state_r == CMTC_RUN);
   // drain only when the pacing allows, so the fifo can really fill
   assign fp.rdReady = srTick;
   assign wrTake     = fp.rdValid && fp.rdReady;

   // ==========================================================
   // decode
   // ==========================================================
   assign cwLoad = directControl
                 || (orderControl && ctrl_r[CW_CC_HI:CW_CC_LO] == CC_NORMAL);
   assign cwNew  = directControl ? directData : orderAddressWord;
   assign masterReset = cwLoad && cwNew[CW_MRST];
   assign sioAccept   = startIo && channelIdleEnable && (state_r == CMTC_IDLE);
   assign startIoRejected = startIo && !sioAccept;
   assign cmpFail = wrTake && ctrl_r[CW_CMP] && (fp.rdData != cb_r);

   // counted event per counter/buffer mode
   always_comb
   begin
      countEvt = 1'b0;
      unique case (ctrl_r[CW_CB_HI:CW_CB_LO])
         CB_CNT_WR : countEvt = wrTake;
         CB_CNT_RD : countEvt = readValid && readReady;
         CB_CNT_SR : countEvt = channelServiceRequest;
         CB_CNT_OR : countEvt = orderControl || orderRead || orderWrite;
         default   : countEvt = 1'b0;                                        // buffer mode
      endcase
   end
   assign rollover  = countEvt && (cb_r == 16'hFFFF);
   assign terminate = (rollover && ctrl_r[CW_TTC])
                    || (cmpFail && ctrl_r[CW_CMP]);

   // ==========================================================
   // control register and jump flag
   // ==========================================================
   always_ff @(posedge clock)
   begin
      if (!rst_b || masterReset)
      begin
         ctrl_r <= WORD_ZERO;
         jump_r <= 1'b0;
      end
      else if (cwLoad)
      begin
         ctrl_r <= cwNew;
         if (cwNew[CW_JUMP])
         begin
            jump_r <= 1'b1;
         end
      end
   end

   // ==========================================================
   // counter/buffer
   // ==========================================================
   always_comb
   begin
      cbNxt = cb_r;
      if (directWrite)
      begin
         cbNxt = directData;
      end
      else if (orderControl)
      begin
         unique case (ctrl_r[CW_CC_HI:CW_CC_LO])
            CC_ADDR : cbNxt = orderAddressWord;
            CC_CTRL : cbNxt = orderControlWord;
            CC_BOTH : cbNxt = orderControlWord;
            // normal mode leaves the words alone, but a counted order still counts
            CC_NORMAL : cbNxt = countEvt ? cb_r + 16'h0001 : cb_r;
         endcase
      end
      else if (ctrl_r[CW_CB_HI:CW_CB_LO] == CB_BUFFER)
      begin
         if (wrTake && !ctrl_r[CW_CMP])
         begin
            cbNxt = fp.rdData;
         end
      end
      else if (countEvt)
      begin
         cbNxt = cb_r + 16'h0001;
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_b || masterReset)
      begin
         cb_r <= WORD_ZERO;                                   // zero gives jump to 0
      end
      else
      begin
         cb_r <= cbNxt;
      end
   end

   // ==========================================================
   // program sequencer
   // ==========================================================
   always_ff @(posedge clock)
   begin
      if (!rst_b || masterReset)
      begin
         state_r <= CMTC_IDLE;
      end
      else
      begin
         unique case (state_r)
            CMTC_IDLE : if (sioAccept) state_r <= CMTC_RUN;
            CMTC_RUN  : if (terminate || endOfTransfer) state_r <= CMTC_DONE;
            CMTC_DONE : if (channelIdleEnable) state_r <= CMTC_IDLE;
            default   : state_r <= CMTC_IDLE;
         endcase
      end
   end

   // ==========================================================
   // service request pacing: one tick per 200 kHz period, a tick every cycle when high speed is set
   // ==========================================================
   always_ff @(posedge clock)
   begin
      if (!rst_b || srTick)
      begin
         srCnt_r <= '0;
      end
      else
      begin
         srCnt_r <= srCnt_r + 1'b1;
      end
   end
   assign srTick = ctrl_r[CW_HSPD]
                 || (srCnt_r == ($bits(srCnt_r))'(SR_DELAY_CYC - 1));
   // request while a write word is wanted or a read is pending
   assign channelServiceRequest = (state_r == CMTC_RUN) && srTick
                                && (fp.wrReady || readValid);

   // ==========================================================
   // channel answers
   // ==========================================================
   always_ff @(posedge clock)
   begin
      if (!rst_b)
      begin
         deviceEnd      <= 1'b0;
         clearInterface <= 1'b0;
         readValid      <= 1'b0;
         readData       <= WORD_ZERO;
         jumpMet        <= 1'b0;
         programDevNum  <= WORD_ZERO;
         directResult   <= WORD_ZERO;
      end
      else
      begin
         // device end: forced at transfer start, or chosen termination
         deviceEnd <= (transferStart && ctrl_r[CW_DEND])
                   || (terminate && !ctrl_r[CW_CLRI]);
         clearInterface <= (terminate && ctrl_r[CW_CLRI])
                        || (masterReset && !channelIdleEnable);
         if (orderRead && !ctrl_r[CW_DEND])
         begin
            readValid <= 1'b1;
            readData  <= cb_r;
         end
         else if (readReady)
         begin
            readValid <= 1'b0;
         end
         jumpMet <= orderJump && jump_r;
         if (sioAccept)
         begin
            programDevNum <= ctrl_r[CW_DNUM] ? cb_r : {8'h00, wiredDevNum};
         end
         if (directRead)
         begin
            directResult <= cb_r;
         end
         else if (directStatus)
         begin
            directResult <= statusWord;
         end
      end
   end

   // ==========================================================
   // interrupt request: set wins over clear
   // ==========================================================
   always_ff @(posedge clock)
   begin
      if (!rst_b)
      begin
         intReq_r <= 1'b0;
      end
      else if (setIntReq)
      begin
         intReq_r <= 1'b1;
      end
      else if (cwLoad && cwNew[CW_RINT])
      begin
         intReq_r <= 1'b0;
      end
   end
   assign intRequest = intReq_r;

   // ==========================================================
   // sticky status flags; sets win over clears
   // ==========================================================
   logic clrAll;                               // accepted start io
   logic clrXfer;                              // start of a data transfer
   assign clrAll  = sioAccept;
   assign clrXfer = clrAll || transferStart;

   always_ff @(posedge clock)
   begin
      if (!rst_b)
      begin
         xerr_r <= 1'b0;
         dend_r <= 1'b0;
         eot_r  <= 1'b0;
         in_r   <= 1'b0;
         out_r  <= 1'b0;
         tcnt_r <= 1'b0;
         ncmp_r <= 1'b0;
         clri_r <= 1'b0;
      end
      else
      begin
         xerr_r <= transferErrorSignal || (xerr_r && !clrAll);
         dend_r <= deviceEnd || (dend_r && !clrXfer);
         eot_r  <= endOfTransfer || (eot_r && !clrXfer);
         tcnt_r <= rollover || (tcnt_r && !clrXfer);
         ncmp_r <= cmpFail || (ncmp_r && !clrXfer);
         clri_r <= clearInterface || (clri_r && !clrAll);
         // direction of the latest transfer
         if (orderRead)
         begin
            in_r  <= 1'b1;
            out_r <= 1'b0;
         end
         else if (orderWrite)
         begin
            in_r  <= 1'b0;
            out_r <= 1'b1;
         end
         else if (clrAll)
         begin
            in_r  <= 1'b0;
            out_r <= 1'b0;
         end
      end
   end

   // ==========================================================
   // status word assembly
   // ==========================================================
   always_comb
   begin
      statusWord          = WORD_ZERO;
      statusWord[SW_SIOK] = (state_r == CMTC_IDLE) && channelIdleEnable;
      statusWord[SW_RWOK] = 1'b1;
      statusWord[SW_IPND] = intReq_r;
      statusWord[SW_IACT] = intActive;
      statusWord[SW_XERR] = xerr_r;
      statusWord[SW_IDLE] = channelIdleEnable;
      statusWord[SW_DEND] = dend_r;
      statusWord[SW_EOT]  = eot_r;
      statusWord[SW_IN]   = in_r;
      statusWord[SW_OUT]  = out_r;
      statusWord[SW_TCNT] = tcnt_r;
      statusWord[SW_NCMP] = ncmp_r;
      statusWord[SW_CLRI] = clri_r;
   end
endmodule

// ==== bench/cmtc_channel_maint_checker.sv ====
`timescale 1ns/1ps
module cmtc_channel_maint_checker
   import cmtc_pkg::*;
(
   // clock and reset
   input wire logic        clock,
   input wire logic        rst_b,
   // watched ports
   input wire logic        directStatus,
   input wire logic        directControl,
   input wire logic        setIntReq,
   input wire logic        intActive,
   input wire logic        intRequest,
   input wire logic        startIo,
   input wire logic        startIoRejected,
   input wire logic        channelIdleEnable,
   input wire logic        deviceEnd,
   input wire logic        clearInterface,
   input wire logic        readValid,
   input wire logic        readReady,
   input wire logic [15:0] readData,
   input wire logic [15:0] directResult
);
   // ==========================================
   // status answers one edge after the request
   default clocking cbk @(posedge clock);
   endclocking
   default disable iff (!rst_b);
   sequence s_ask;
      directStatus ##1 1'b1;
   endsequence
   // interrupt edits in the same cycle would race the capture
   sequence s_askq;
      (directStatus && !setIntReq && !directControl) ##1 1'b1;
   endsequence
   property p_rwok;
      s_ask |-> directResult[SW_RWOK];
   endproperty
   a_rwok: assert property (p_rwok) else $error("rwok bit low");
   property p_siok;
      s_ask |-> !directResult[SW_SIOK] || $past(channelIdleEnable);
   endproperty
   a_siok: assert property (p_siok) else $error("siok while busy");
   property p_idle;
      s_ask |-> directResult[SW_IDLE] == $past(channelIdleEnable);
   endproperty
   a_idle: assert property (p_idle) else $error("idle bit wrong");
   property p_iact;
      s_ask |-> directResult[SW_IACT] == $past(intActive);
   endproperty
   a_iact: assert property (p_iact) else $error("active bit wrong");
   property p_ipnd;
      s_askq |-> directResult[SW_IPND] == $past(intRequest);
   endproperty
   a_ipnd: assert property (p_ipnd) else $error("pending bit wrong");
   property p_rej;
      startIo && !channelIdleEnable |-> startIoRejected;
   endproperty
   a_rej: assert property (p_rej) else $error("start not refused");
   property p_excl;
      !(deviceEnd && clearInterface);
   endproperty
   a_excl: assert property (p_excl) else $error("both endings");
   property p_rdhold;
      readValid && !readReady |=> readValid && $stable(readData);
   endproperty
   a_rdhold: assert property (p_rdhold) else $error("read word dropped");
endmodule
bind cmtc_channel_maint cmtc_channel_maint_checker chk (.*);

// ==== bench/cmtc_chan_model.sv ====
`timescale 1ns/1ps
module cmtc_chan_model
(
   input  wire logic        clock,
   input  wire logic        writeReady,
   output      logic        channelIdleEnable,
   output      logic        orderControl,
   output      logic        orderWrite,
   output      logic        orderRead,
   output      logic        orderJump,
   output      logic        transferStart,
   output      logic [15:0] orderAddressWord,
   output      logic [15:0] orderControlWord,
   output      logic        writeValid,
   output      logic [15:0] writeData,
   output      logic        readReady,
   output      logic        endOfTransfer,
   output      logic        transferErrorSignal
);
   // ==========================================
   // channel side, idle until told otherwise
   logic [4:0] pls = 5'h00;
   assign {orderControl, orderWrite, orderRead, orderJump, transferStart} = pls;
   initial
   begin
      channelIdleEnable = 1'b1;
      orderAddressWord = 16'h0000;
      orderControlWord = 16'h0000;
      writeValid = 1'b0;
      writeData = 16'h0000;
      readReady = 1'b0;
      endOfTransfer = 1'b0;
      transferErrorSignal = 1'b0;
   end
   // stall every other cycle so read words must stand
   always @(posedge clock)
      readReady <= ~readReady;
   // one order pulse; released words show their inverse
   task automatic order(input logic [4:0] w, input logic [15:0] aw, input logic [15:0] cw);
      @(posedge clock);
      pls <= w;
      orderAddressWord <= aw;
      orderControlWord <= cw;
      @(posedge clock);
      pls <= 5'h00;
      orderAddressWord <= ~aw;
      orderControlWord <= ~cw;
   endtask
   // hold the word until ready is seen, give up after four edges
   task automatic push(input logic [15:0] d, output bit ok);
      ok = 1'b0;
      @(posedge clock);
      writeValid <= 1'b1;
      writeData <= d;
      for (int n = 0; n < 4 && !ok; n++)
      begin
         @(posedge clock);
         ok = (writeReady === 1'b1);
      end
      writeValid <= 1'b0;
      writeData <= ~d;
   endtask
endmodule

// ==== bench/test_channel_maintenance_test_controller.sv ====
`timescale 1ns/1ps
module test_channel_maintenance_test_controller;
   import cmtc_pkg::*;
   // ==========================================
   // stimulus and wiring
   logic        clock = 1'b0;
   logic        rst_b = 1'b0;
   logic [5:0]  dp = 6'h00;              // direct instruction pulses
   logic [15:0] directData = 16'h0000;
   logic        intActive = 1'b0;
   logic [7:0]  wiredDevNum = 8'h5C;     // tied board number
   wire directControl, directWrite, directRead, directStatus, startIo, setIntReq;
   wire channelIdleEnable, orderControl, orderWrite, orderRead, orderJump, transferStart;
   wire writeValid, readReady, endOfTransfer, transferErrorSignal, startIoRejected;
   wire writeReady, readValid, channelServiceRequest, deviceEnd, clearInterface;
   wire jumpMet, intRequest;
   wire [15:0] orderAddressWord, orderControlWord, writeData, directResult;
   wire [15:0] readData, programDevNum;
   int miscompares = 0;
   int totalChecks = 0;
   localparam logic [5:0] DCTL = 6'h20, DWR = 6'h10, DRD = 6'h08, DST = 6'h04, DSIO = 6'h02;
   localparam logic [15:0] AW = 16'h00A0, CW = 16'h5A5A, PRE = 16'h0F0F, ONE = 16'h0001;
   localparam logic [15:0] ST0 = (ONE << SW_SIOK) | (ONE << SW_RWOK) | (ONE << SW_IDLE);
   // control code rows: control word, expected counter/buffer
   logic [15:0] rows [4][2] = '{'{16'h0000, PRE}, '{16'h0100, AW}, '{16'h0200, CW},
                                '{16'h0300, CW}};
   assign {directControl, directWrite, directRead, directStatus, startIo, setIntReq} = dp;
   cmtc_channel_maint uut (.*);
   cmtc_chan_model chan (.*);
   initial
   begin
      forever #2 clock = ~clock;
   end
   // ==========================================
   // shared tasks
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      totalChecks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic dio(input logic [5:0] p, input logic [15:0] d);
      @(posedge clock);
      dp <= p;
      directData <= d;
      @(posedge clock);
      dp <= 6'h00;
      directData <= ~d;
   endtask
   task automatic look(input logic [5:0] p, output logic [15:0] v);
      dio(p, 16'h0000);
      #1 v = directResult;
   endtask
   // program start with the channel idle, then the channel goes busy
   task automatic restart();
      chan.channelIdleEnable <= 1'b1;
      dio(DSIO, 16'h0000);
      chan.channelIdleEnable <= 1'b0;
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", totalChecks, miscompares);
      if (miscompares == 0 && totalChecks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // watchdog well past the expected run
   initial
   begin
      #200000;
      miscompares++;
      report_and_stop();
   end
   // ==========================================
   // main sequence
   initial
   begin
      logic [15:0] v;
      bit ok;
      int n;
      repeat (8) @(posedge clock);
      rst_b <= 1'b1;
      look(DST, v);
      chk(v, ST0);
      look(DRD, v);
      chk(v, WORD_ZERO);
      dio(6'h01, 16'h0000);
      look(DST, v);
      chk(v, ST0 | (ONE << SW_IPND));
      restart();
      #1 chk(programDevNum, {8'h00, wiredDevNum});
      @(posedge clock);
      dp <= DSIO;
      #1 chk({15'h0000, startIoRejected}, ONE);
      @(posedge clock);
      dp <= 6'h00;
      foreach (rows[i])
      begin
         dio(DCTL, rows[i][0]);
         dio(DWR, PRE);
         chan.order(5'h10, AW, CW);
         look(DRD, v);
         chk(v, rows[i][1]);
      end
      dio(DCTL, ONE << CW_JUMP);
      chan.order(5'h02, AW, CW);
      #1 chk({15'h0000, jumpMet}, ONE);
      // compare failure, clear interface then device end
      for (int k = 0; k < 2; k++)
      begin
         restart();
         look(DST, v);
         chk({v[SW_NCMP], v[SW_CLRI]}, 16'h0000);
         dio(DCTL, (ONE << CW_CMP) | (ONE << CW_HSPD) | ((k == 0) ? ONE << CW_CLRI : 16'h0000));
         dio(DWR, 16'h1234);
         chan.order(5'h09, AW, CW);
         chan.push(16'h4321, ok);
         for (n = 0; n < 200 && !((k == 0) ? clearInterface : deviceEnd); n++)
            @(posedge clock);
         chk(n < 200, ONE);
         look(DRD, v);
         chk(v, 16'h1234);
         look(DST, v);
         chk({v[SW_NCMP], v[SW_CLRI], v[SW_DEND]}, {1'b1, k == 0, k == 1});
      end
      chan.transferErrorSignal <= 1'b1;
      @(posedge clock);
      chan.transferErrorSignal <= 1'b0;
      look(DST, v);
      chk(v[SW_XERR], ONE);
      restart();
      look(DST, v);
      chk(v[SW_XERR], 16'h0000);
      // fill the buffer while pacing is slow, then drain at full speed
      dio(DCTL, 16'h0000);
      chan.order(5'h09, AW, CW);
      for (n = 0; n < 40; n++)
      begin
         chan.push(16'(16'h0100 + n), ok);
         if (!ok)
            break;
      end
      chk(n >= 32, ONE);
      dio(DCTL, ONE << CW_HSPD);
      repeat (100) @(posedge clock);
      #1 chk({15'h0000, channelServiceRequest}, ONE);
      look(DRD, v);
      chk(v, 16'(16'h0100 + n - 1));
      chan.order(5'h05, AW, CW);
      for (n = 0; n < 3000 && !(readValid === 1'b1 && readReady === 1'b1); n++)
         @(posedge clock);
      chk(readData, v);
      // end of transfer stops the program so that a new start is taken
      chan.endOfTransfer <= 1'b1;
      @(posedge clock);
      chan.endOfTransfer <= 1'b0;
      look(DST, v);
      chk({v[SW_EOT], v[SW_IN], v[SW_OUT]}, 16'h0006);
      dio(DWR, 16'h00C3);
      dio(DCTL, ONE << CW_DNUM);
      restart();
      #1 chk(programDevNum, 16'h00C3);
      // master reset with the channel busy also clears the interface
      dio(DCTL, ONE << CW_MRST);
      #1 chk({15'h0000, clearInterface}, ONE);
      look(DRD, v);
      chk(v, WORD_ZERO);
      report_and_stop();
   end
endmodule
